// >>> test/ecp_parallel_port_registers_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ecp_parallel_port_registers_tb;
  typedef struct packed {logic [10:0] a; logic w; logic n; logic [7:0] d;} pp_row_t;
  logic sys_clk, rst_b, chip_sel, aen, io_write_strobe_b, io_read_strobe_b;
  logic dma_ack_b, dma_tc, fault_b, ack_go;
  logic [10:0] io_addr;
  logic [7:0] host_data_in, v;
  wire [7:0] host_data_out, pins_out, pins_in;
  wire host_data_oe, dma_req, irq_out, pins_oe, stb, afd, ini, sel, err, slct, pap, ack, busy;
  int error_cnt = 0;
  int checked = 0;
  int irqs = 0;
  int i0;
  pp_row_t rows [16] = '{
    '{11'h402, 1'b0, 1'b0, 8'h15},
    '{11'h002, 1'b0, 1'b0, 8'h00},
    '{11'h000, 1'b0, 1'b0, 8'h00},
    '{11'h001, 1'b0, 1'b0, 8'hd8},
    '{11'h000, 1'b1, 1'b0, 8'ha5},
    '{11'h000, 1'b0, 1'b0, 8'ha5},
    '{11'h000, 1'b1, 1'b1, 8'h3c},
    '{11'h000, 1'b0, 1'b0, 8'ha5},
    '{11'h001, 1'b0, 1'b1, 8'h00},
    '{11'h002, 1'b1, 1'b0, 8'hdf},
    '{11'h002, 1'b0, 1'b0, 8'h1f},
    '{11'h002, 1'b1, 1'b0, 8'h00},
    '{11'h402, 1'b1, 1'b0, 8'hf4},
    '{11'h400, 1'b0, 1'b0, 8'h10},
    '{11'h401, 1'b1, 1'b0, 8'hff},
    '{11'h401, 1'b0, 1'b0, 8'h00}};
  pp_ecp_port #(.SETUP_CYC(2)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .chip_sel(chip_sel),
    .aen(aen), .io_addr(io_addr), .io_write_strobe_b(io_write_strobe_b),
    .io_read_strobe_b(io_read_strobe_b), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .dma_req(dma_req),
    .dma_ack_b(dma_ack_b), .dma_tc(dma_tc), .irq_out(irq_out),
    .port_data_pins_in(pins_in), .port_data_pins_out(pins_out), .port_data_pins_oe(pins_oe),
    .write_strobe_out(stb), .auto_feed_out(afd), .initialize_out(ini), .select_in_out(sel),
    .peripheral_error_in(err), .select_line_in(slct), .paper_error_in(pap),
    .peripheral_ack_in(ack), .busy_in(busy));
  pp_printer_model prn (.sys_clk(sys_clk), .write_strobe_out(stb), .auto_feed_out(afd),
    .port_data_pins_out(pins_out), .port_data_pins_oe(pins_oe), .fault_b(fault_b),
    .ack_go(ack_go), .busy_in(busy), .peripheral_ack_in(ack), .peripheral_error_in(err),
    .select_line_in(slct), .paper_error_in(pap), .port_data_pins_in(pins_in));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (irq_out === 1'b1) irqs++;
  task automatic close_out;
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic n = 1'b0);
    aen = n;
    io_addr = a;
    host_data_in = d;
    io_write_strobe_b = 1'b0;
    cyc;
    io_write_strobe_b = 1'b1;
    cyc;
    cyc;
  endtask
  task automatic rd(input logic [10:0] a, input logic n, output logic [7:0] q);
    aen = n;
    io_addr = a;
    io_read_strobe_b = 1'b0;
    cyc;
    cyc;
    q = host_data_out;
    chk(host_data_oe, !n);
    io_read_strobe_b = 1'b1;
    cyc;
    cyc;
  endtask
  task automatic await(input int n);
    for (int t = 0; t < 300 && prn.got.size() < n; t++) cyc;
    repeat (20) cyc;
  endtask
  initial begin
    #200000;
    error_cnt++;
    close_out;
  end
  initial begin
    {rst_b, aen, dma_tc, ack_go} = 4'h0;
    {chip_sel, io_write_strobe_b, io_read_strobe_b, dma_ack_b, fault_b} = 5'h1f;
    io_addr = 11'h000;
    host_data_in = 8'h00;
    repeat (3) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d, rows[k].n);
      else begin
        rd(rows[k].a, rows[k].n, v);
        if (!rows[k].n) chk(v, rows[k].d);
      end
    end
    wr(11'h002, 8'h0f);
    chk({stb, afd, ini, sel}, 4'h2);
    wr(11'h002, 8'h00);
    chk({stb, afd, ini, sel}, 4'hd);
    // ==========================================
    // test fifo: fill past full, drain past empty
    wr(11'h402, 8'h14);
    wr(11'h402, 8'hd4);
    for (int i = 0; i < 16; i++) wr(11'h400, 8'h40 + i);
    rd(11'h402, 1'b0, v);
    chk(v[1:0], 2'b10);
    wr(11'h400, 8'hee);
    for (int i = 0; i < 16; i++) begin
      rd(11'h400, 1'b0, v);
      chk(v, 8'h40 + i);
    end
    rd(11'h400, 1'b0, v);
    chk(v, 8'h4f);
    // ==========================================
    // service request on free space, then a software set
    i0 = irqs;
    wr(11'h402, 8'hd0);
    rd(11'h402, 1'b0, v);
    chk(v, 8'hd5);
    wr(11'h402, 8'hd4);
    chk(irqs, i0 + 1);
    // ==========================================
    // acknowledge interrupt in standard mode
    wr(11'h402, 8'h14);
    wr(11'h002, 8'h10);
    ack_go = 1'b1;
    repeat (8) cyc;
    ack_go = 1'b0;
    chk(irqs, i0 + 2);
    wr(11'h002, 8'h00);
    // ==========================================
    // dma in test mode: terminal count sets service and stops requests
    wr(11'h402, 8'hd8);
    chk(dma_req, 1'b1);
    dma_ack_b = 1'b0;
    dma_tc = 1'b1;
    host_data_in = 8'h5a;
    io_write_strobe_b = 1'b0;
    cyc;
    io_write_strobe_b = 1'b1;
    cyc;
    cyc;
    chk(dma_req, 1'b0);
    dma_ack_b = 1'b1;
    dma_tc = 1'b0;
    rd(11'h402, 1'b0, v);
    chk(v, 8'hdc);
    rd(11'h400, 1'b0, v);
    chk(v, 8'h5a);
    // fifo modes are left through 000 or 001 only
    wr(11'h402, 8'h14);
    // ==========================================
    // forward links: fifo mode, then command and data bytes
    prn.got.delete();
    wr(11'h402, 8'h54);
    wr(11'h400, 8'h3c);
    wr(11'h400, 8'hc3);
    await(2);
    wr(11'h402, 8'h14);
    wr(11'h402, 8'h74);
    wr(11'h000, 8'h81);
    wr(11'h400, 8'h22);
    await(4);
    chk(prn.got[0], 9'h13c);
    chk(prn.got[1], 9'h1c3);
    chk(prn.got[2], 9'h081);
    chk(prn.got[3], 9'h122);
    // ==========================================
    // fault edge and unmasking while fault is low
    i0 = irqs;
    wr(11'h402, 8'h64);
    fault_b = 1'b0;
    repeat (4) cyc;
    chk(irqs, i0 + 1);
    wr(11'h402, 8'h74);
    wr(11'h402, 8'h64);
    chk(irqs, i0 + 2);
    fault_b = 1'b1;
    // ==========================================
    // reverse link: a released bus reads back inverted
    // direction changes only in mode 001
    wr(11'h402, 8'h34);
    wr(11'h002, 8'h20);
    wr(11'h402, 8'h74);
    cyc;
    chk(afd, 1'b0);
    ack_go = 1'b1;
    repeat (8) cyc;
    ack_go = 1'b0;
    rd(11'h400, 1'b0, v);
    chk(v, 8'h5a);
    // ==========================================
    // reset in mid-run
    rst_b = 1'b0;
    repeat (3) cyc;
    rst_b = 1'b1;
    rd(11'h402, 1'b0, v);
    chk(v, 8'h15);
    rd(11'h000, 1'b0, v);
    chk(v, 8'h00);
    close_out;
  end
endmodule
`default_nettype wire

// >>> test/pp_ecp_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port-level checks of the parallel port
module pp_ecp_checker (
  input wire sys_clk,
  input wire rst_b,
  input wire chip_sel,
  input wire aen,
  input wire [10:0] io_addr,
  input wire io_read_strobe_b,
  input wire dma_ack_b,
  input wire [7:0] host_data_out,
  input wire host_data_oe,
  input wire dma_req,
  input wire irq_out,
  input wire [7:0] port_data_pins_out,
  input wire port_data_pins_oe,
  input wire write_strobe_out,
  input wire auto_feed_out,
  input wire initialize_out,
  input wire select_in_out,
  input wire busy_in
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire dec = chip_sel && !aen && dma_ack_b;
  property p_rst_lines;
    $rose(rst_b) |-> write_strobe_out && auto_feed_out && select_in_out && !initialize_out;
  endproperty
  a_rst_lines: assert property (p_rst_lines) else $error("lines wrong after reset");
  property p_rst_pins;
    $rose(rst_b) |-> port_data_pins_oe && port_data_pins_out == 8'h00;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("data pins wrong after reset");
  property p_rst_req;
    $rose(rst_b) |-> !dma_req && !irq_out;
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("request after reset");
  property p_ignored;
    $fell(io_read_strobe_b) && aen && dma_ack_b |-> ##2 !host_data_oe;
  endproperty
  a_ignored: assert property (p_ignored) else $error("read answered with aen high");
  property p_oe;
    $fell(io_read_strobe_b) && dec && (io_addr <= 11'h002 || io_addr == 11'h402)
      |-> ##2 host_data_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("decoded read not answered");
  property p_drop;
    io_read_strobe_b [*2] |=> !host_data_oe;
  endproperty
  a_drop: assert property (p_drop) else $error("read drive held too long");
  property p_stat;
    $fell(io_read_strobe_b) && dec && io_addr == 11'h001 && $stable(busy_in)
      |-> ##2 host_data_out[2:0] == 3'h0 && host_data_out[7] == !$past(busy_in, 2);
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_ctrl;
    $fell(io_read_strobe_b) && dec && io_addr == 11'h002 |-> ##2 host_data_out[7:6] == 2'h0;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control top bits not zero");
  property p_cfgb;
    $fell(io_read_strobe_b) && dec && io_addr == 11'h401
      |-> ##2 {host_data_out[7], host_data_out[5:0]} == 7'h00;
  endproperty
  a_cfgb: assert property (p_cfgb) else $error("config b fixed bits wrong");
  property p_pulse;
    irq_out |=> !irq_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("interrupt longer than a pulse");
  c_irq: cover property (irq_out);
  c_strobe: cover property ($fell(write_strobe_out));
  c_stat: cover property ($fell(io_read_strobe_b) && dec && io_addr == 11'h001);
endmodule

bind pp_ecp_port pp_ecp_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .chip_sel(chip_sel),
  .aen(aen), .io_addr(io_addr), .io_read_strobe_b(io_read_strobe_b), .dma_ack_b(dma_ack_b),
  .host_data_out(host_data_out), .host_data_oe(host_data_oe), .dma_req(dma_req),
  .irq_out(irq_out), .port_data_pins_out(port_data_pins_out),
  .port_data_pins_oe(port_data_pins_oe), .write_strobe_out(write_strobe_out),
  .auto_feed_out(auto_feed_out), .initialize_out(initialize_out),
  .select_in_out(select_in_out), .busy_in(busy_in));
`default_nettype wire

// >>> test/pp_printer_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// peripheral on the far side of the port
module pp_printer_model (
  input wire sys_clk,
  input wire write_strobe_out,
  input wire auto_feed_out,
  input wire [7:0] port_data_pins_out,
  input wire port_data_pins_oe,
  input wire fault_b,
  input wire ack_go,
  output logic busy_in,
  output logic peripheral_ack_in,
  output wire peripheral_error_in,
  output wire select_line_in,
  output wire paper_error_in,
  output wire [7:0] port_data_pins_in
);
  logic [8:0] got[$];
  logic [7:0] last = 8'h00;
  assign peripheral_error_in = fault_b;
  assign select_line_in = 1'b1;
  assign paper_error_in = 1'b0;
  // a released bus must not keep showing the old byte
  assign port_data_pins_in = port_data_pins_oe ? port_data_pins_out : ~last;
  always @(posedge sys_clk) if (port_data_pins_oe) last <= port_data_pins_out;
  initial begin
    busy_in = 1'b0;
    peripheral_ack_in = 1'b1;
  end
  always @(negedge write_strobe_out) begin
    got.push_back({auto_feed_out, port_data_pins_out});
    repeat (2) @(posedge sys_clk);
    busy_in <= 1'b1;
    wait (write_strobe_out);
    repeat (2) @(posedge sys_clk);
    busy_in <= 1'b0;
  end
  always @(posedge ack_go) begin
    peripheral_ack_in <= 1'b0;
    repeat (3) @(posedge sys_clk);
    peripheral_ack_in <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> verilog/pp_defines.vh
`ifndef PP_DEFINES_VH
`define PP_DEFINES_VH
// ==========================================
// register offsets from the port base
`define PP_OFF_DATA 11'h000
`define PP_OFF_STATUS 11'h001
`define PP_OFF_CTRL 11'h002
`define PP_OFF_FIFO 11'h400
`define PP_OFF_CFGB 11'h401
`define PP_OFF_ECR 11'h402
// ==========================================
// mode field codes
`define PP_MODE_STD 3'h0
`define PP_MODE_BIDIR 3'h1
`define PP_MODE_PFIFO 3'h2
`define PP_MODE_ECP 3'h3
`define PP_MODE_EPP 3'h4
`define PP_MODE_TEST 3'h6
`define PP_MODE_CFG 3'h7
// ==========================================
// field positions
`define PP_CTRL_STROBE 0
`define PP_CTRL_AUTOFD 1
`define PP_CTRL_INIT 2
`define PP_CTRL_SELIN 3
`define PP_CTRL_ACKIE 4
`define PP_CTRL_DIR 5
`define PP_ECR_MODE_HI 7
`define PP_ECR_MODE_LO 5
`define PP_ECR_FMASK 4
`define PP_ECR_DMA_ENABLE_BIT 3
`define PP_ECR_SVC 2
`define PP_ECR_FULL 1
`define PP_ECR_EMPTY 0
`define PP_CFGB_IRQ 6
// ==========================================
// reset and fixed values
`define PP_DATA_RST 8'h00
`define PP_CTRL_RST 6'h00
`define PP_ECR_RST 6'h05
`define PP_CFGA_VAL 8'h10
// ==========================================
// fifo and timing
`define PP_FIFO_DEPTH 16
`define PP_FREE_THRESH 5'h08
`define PP_FILL_THRESH 5'h08
`define PP_CLK_NS 10
`define PP_SETUP_NS 500
`define PP_SETUP_CYC ((`PP_SETUP_NS + `PP_CLK_NS - 1) / `PP_CLK_NS)
`endif

// >>> verilog/pp_ecp_port.v
// How it works
// - extended registers sit at base plus 0x400..0x402, chosen by mode
// - extended control bits 7..5 hold the read/write three-bit mode
// - every host access is ignored while address enable is high
// - modes 000/001: data latch resets clear, loads on write end, reads pins
// - mode 011 forward writes at offset 0 enter fifo tagged as command bytes
// - status bits 2..0 zero; 3..6 fault, select, paper error, ack levels
// - status bit 7 is the inverted busy input
// - control bits 5..0 reset to zero; bits 7..6 read zero
// - control bits 0,1,3 drive strobe, autofeed, select-in inverted; bit 2 init
// - with ack enable set, a rising ack raises an interrupt
// - control bit 5 is direction, forced outward in modes 000 and 010
// - mode 010 fifo bytes go out by automatic standard handshake
// - mode 011 fifo sends forward by handshake, collects peripheral bytes in reverse
// - mode 110 fifo takes host reads and writes, never handshakes out
// - test fifo never stalls: full writes dropped, empty reads repeat last byte
// - fifo reads always return bytes in write order
// - mode 111 offset 0x400 reads fixed 0x10
// - config B: bit 7 zero, bit 6 irq line level, bits 5..0 zero
// - fault mask, mode 011 only: falling fault interrupts when clear; clearing during fault interrupts
// - dma enable bit allows dma only while service bit is zero
// - hardware sets service bit after service event; software writes zero to re-arm
// - with dma enabled, terminal count sets the service bit
// - without dma, free or filled bytes reaching threshold set service bit
// - extended control bit 1 reads fifo full, ignores writes
// - extended control bit 0 reads fifo empty, ignores writes
// - all fifo modes share one sixteen-byte fifo
`include "pp_defines.vh"
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// byte fifo with valid/ready on both sides
module pp_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire rst_b,
  input wire flush,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign level = count;
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always @(posedge sys_clk) begin
    if (!rst_b || flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ==========================================
// parallel port register set and link engine
module pp_ecp_port #(
  parameter SETUP_CYC = `PP_SETUP_CYC
) (
  input wire sys_clk,
  input wire rst_b,
  input wire chip_sel,
  input wire aen,
  input wire [10:0] io_addr,
  input wire io_write_strobe_b,
  input wire io_read_strobe_b,
  input wire [7:0] host_data_in,
  output reg [7:0] host_data_out,
  output reg host_data_oe,
  output reg dma_req,
  input wire dma_ack_b,
  input wire dma_tc,
  output reg irq_out,
  input wire [7:0] port_data_pins_in,
  output reg [7:0] port_data_pins_out,
  output reg port_data_pins_oe,
  output reg write_strobe_out,
  output reg auto_feed_out,
  output reg initialize_out,
  output reg select_in_out,
  input wire peripheral_error_in,
  input wire select_line_in,
  input wire paper_error_in,
  input wire peripheral_ack_in,
  input wire busy_in
);
  localparam S_IDLE = 5'h01;
  localparam S_SETUP = 5'h02;
  localparam S_STROBE = 5'h04;
  localparam S_WAIT = 5'h08;
  localparam S_REV = 5'h10;

  reg [7:0] data_latch;
  reg [5:0] ctrl;
  reg [2:0] mode;
  reg fault_mask;
  reg dma_en;
  reg service;
  reg prev_wr_b;
  reg prev_rd_b;
  reg prev_ack;
  reg prev_fault;
  reg [7:0] last_byte;
  reg [4:0] state;
  reg [7:0] cnt;
  reg [7:0] link_byte;
  reg link_tag;
  reg link_strobe;
  reg link_feed;
  reg link_pop;
  reg link_push;
  reg [7:0] next_read;
  reg next_hit;

  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [8:0] fifo_head;
  wire [4:0] fifo_level;

  // ==========================================
  // access qualification
  wire wr_end = ~prev_wr_b & io_write_strobe_b;
  wire rd_begin = prev_rd_b & ~io_read_strobe_b;
  wire rd_end = ~prev_rd_b & io_read_strobe_b;
  wire dma_cyc = ~dma_ack_b;
  wire host_cyc = chip_sel & ~aen & dma_ack_b;
  wire a_data = host_cyc & (io_addr == `PP_OFF_DATA);
  wire a_ctrl = host_cyc & (io_addr == `PP_OFF_CTRL);
  wire a_fifo = host_cyc & (io_addr == `PP_OFF_FIFO);
  wire a_ecr = host_cyc & (io_addr == `PP_OFF_ECR);
  wire mode_plain = (mode == `PP_MODE_STD) | (mode == `PP_MODE_BIDIR);
  wire mode_test = (mode == `PP_MODE_TEST);
  wire mode_ecp = (mode == `PP_MODE_ECP);
  wire mode_pf = (mode == `PP_MODE_PFIFO);
  wire fifo_mode = mode_pf | mode_ecp | mode_test;
  // direction forced out in 000 and 010
  wire dir_in = ctrl[`PP_CTRL_DIR] & (mode != `PP_MODE_STD) & ~mode_pf;
  wire fwd_link = (mode_pf | mode_ecp) & ~dir_in;
  wire rev_link = mode_ecp & dir_in;
  wire fifo_full = ~fifo_in_ready;
  wire fifo_empty = ~fifo_out_valid;

  // command-tagged byte at offset 0 in mode 011
  wire push_cmd = wr_end & a_data & mode_ecp & ~dir_in;
  // data fifo writes, host or dma
  wire push_dat = wr_end & (a_fifo | dma_cyc) & ((fwd_link) | mode_test);
  wire host_push = push_cmd | push_dat;
  wire host_pop = rd_end & (a_fifo | dma_cyc) & (rev_link | mode_test);
  wire [8:0] push_word = link_push ? {1'b0, link_byte} : {push_cmd, host_data_in};

  // one shared fifo, flushed in plain modes
  pp_fifo #(
    .WIDTH(9),
    .DEPTH(`PP_FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .flush(mode_plain),
    .in_valid(host_push | link_push),
    .in_data(push_word),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_head),
    .out_ready(host_pop | link_pop),
    .level(fifo_level)
  );

  // ==========================================
  // service and interrupt events
  wire [4:0] free_bytes = 5'd16 - fifo_level;
  // terminal count on a dma transfer
  wire tc_hit = dma_en & dma_cyc & dma_tc & (wr_end | rd_end);
  wire thr_hit = ~dma_en & (dir_in ? (fifo_level >= `PP_FILL_THRESH)
                                   : (free_bytes >= `PP_FREE_THRESH));
  // only armed while the service bit is zero
  wire svc_set = ~service & fifo_mode & (tc_hit | thr_hit);
  wire ack_irq = ctrl[`PP_CTRL_ACKIE] & ~prev_ack & peripheral_ack_in;
  // falling fault, or unmasking while fault is low
  wire unmask_wr = wr_end & a_ecr & fault_mask & ~host_data_in[`PP_ECR_FMASK];
  wire fault_irq = mode_ecp & ((~fault_mask & prev_fault & ~peripheral_error_in)
                               | (unmask_wr & ~peripheral_error_in));

  // ==========================================
  // read mux
  always @* begin
    next_read = 8'h00;
    next_hit = 1'b1;
    if (dma_cyc) begin
      next_read = fifo_empty ? last_byte : fifo_head[7:0];
    end else if (!host_cyc) begin
      next_hit = 1'b0;
    end else begin
      case (io_addr)
        `PP_OFF_DATA: next_read = port_data_pins_in;
        `PP_OFF_STATUS: next_read = {~busy_in, peripheral_ack_in, paper_error_in,
                                     select_line_in, peripheral_error_in, 3'h0};
        `PP_OFF_CTRL: next_read = {2'h0, ctrl};
        `PP_OFF_FIFO: begin
          if (mode == `PP_MODE_CFG) begin
            next_read = `PP_CFGA_VAL;
          // head in write order, last byte when empty
          end else begin
            next_read = fifo_empty ? last_byte : fifo_head[7:0];
          end
        end
        `PP_OFF_CFGB: next_read = (mode == `PP_MODE_CFG) ? {1'b0, irq_out, 6'h00} : 8'h00;
        `PP_OFF_ECR: next_read = {mode, fault_mask, dma_en, service, fifo_full, fifo_empty};
        default: next_read = 8'h00;
      endcase
    end
  end

  // ==========================================
  // host registers
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      prev_wr_b <= 1'b1;
      prev_rd_b <= 1'b1;
      prev_ack <= 1'b1;
      prev_fault <= 1'b1;
      data_latch <= `PP_DATA_RST;
      ctrl <= `PP_CTRL_RST;
      {mode, fault_mask, dma_en, service} <= `PP_ECR_RST;
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
      last_byte <= 8'h00;
      irq_out <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      prev_wr_b <= io_write_strobe_b;
      prev_rd_b <= io_read_strobe_b;
      prev_ack <= peripheral_ack_in;
      prev_fault <= peripheral_error_in;
      if (wr_end && a_data && mode_plain) begin
        data_latch <= host_data_in;
      end
      if (wr_end && a_ctrl) begin
        ctrl <= host_data_in[5:0];
      end
      if (wr_end && a_ecr) begin
        mode <= host_data_in[`PP_ECR_MODE_HI:`PP_ECR_MODE_LO];
        fault_mask <= host_data_in[`PP_ECR_FMASK];
        dma_en <= host_data_in[`PP_ECR_DMA_ENABLE_BIT];
      end
      // hardware set wins over a software clear
      if (svc_set) begin
        service <= 1'b1;
      end else if (wr_end && a_ecr) begin
        service <= host_data_in[`PP_ECR_SVC];
      end
      if (rd_begin && next_hit) begin
        host_data_out <= next_read;
        host_data_oe <= 1'b1;
      end else if (io_read_strobe_b) begin
        host_data_oe <= 1'b0;
      end
      if (host_pop && fifo_out_valid) begin
        last_byte <= fifo_head[7:0];
      end
      irq_out <= ack_irq | fault_irq | svc_set;
      // dma only while enabled and service clear
      dma_req <= dma_en & ~service & ~svc_set & (fwd_link | rev_link | mode_test)
                 & (dir_in ? fifo_out_valid : fifo_in_ready);
    end
  end

  // ==========================================
  // link handshake engine
  always @(posedge sys_clk) begin
    if (!rst_b || !(fwd_link || rev_link)) begin
      state <= S_IDLE;
      cnt <= 8'h00;
      link_byte <= 8'h00;
      link_tag <= 1'b0;
      link_strobe <= 1'b1;
      link_feed <= 1'b1;
      link_pop <= 1'b0;
      link_push <= 1'b0;
    end else begin
      link_pop <= 1'b0;
      link_push <= 1'b0;
      case (state)
        S_IDLE: begin
          // forward: take a byte when the peripheral is not busy
          if (fwd_link && fifo_out_valid && !busy_in && !link_pop) begin
            link_byte <= fifo_head[7:0];
            link_tag <= fifo_head[8] & mode_ecp;
            link_feed <= ~(fifo_head[8] & mode_ecp);
            link_pop <= 1'b1;
            cnt <= SETUP_CYC[7:0];
            state <= S_SETUP;
          // reverse: request a byte only while the fifo has room
          end else if (rev_link && fifo_in_ready) begin
            link_feed <= 1'b0;
            state <= S_REV;
          end
        end
        S_SETUP: begin
          if (cnt <= 8'h01) begin
            link_strobe <= 1'b0;
            cnt <= SETUP_CYC[7:0];
            state <= S_STROBE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        S_STROBE: begin
          if (busy_in || (mode_pf && cnt <= 8'h01)) begin
            link_strobe <= 1'b1;
            state <= S_WAIT;
          end else if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
          end
        end
        S_REV: begin
          if (!peripheral_ack_in) begin
            link_byte <= port_data_pins_in;
            link_push <= 1'b1;
            link_feed <= 1'b1;
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (dir_in ? peripheral_ack_in : !busy_in) begin
            link_feed <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================
  // pin drivers
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      port_data_pins_out <= 8'h00;
      port_data_pins_oe <= 1'b1;
      write_strobe_out <= 1'b1;
      auto_feed_out <= 1'b1;
      initialize_out <= 1'b0;
      select_in_out <= 1'b1;
    end else begin
      port_data_pins_oe <= ~dir_in;
      // test mode shows the fifo head but never strobes it
      if (mode_test) begin
        port_data_pins_out <= fifo_head[7:0];
      end else if (fwd_link) begin
        port_data_pins_out <= link_byte;
      end else begin
        port_data_pins_out <= data_latch;
      end
      write_strobe_out <= fwd_link ? link_strobe : ~ctrl[`PP_CTRL_STROBE];
      auto_feed_out <= (fwd_link | rev_link) ? link_feed : ~ctrl[`PP_CTRL_AUTOFD];
      initialize_out <= ctrl[`PP_CTRL_INIT];
      select_in_out <= ~ctrl[`PP_CTRL_SELIN];
    end
  end
endmodule
`default_nettype wire
